// >>> verilog/tol_link_timing.v
// two-channel teleprotection link framer with per-channel timing mode
// Function
// - one 64 kbps timeslot, multiplier one
// - 256-bit frame; 2048 kbps and 8000 Hz in loop mode, internal divider gives 2000 kbps and 7812.5 Hz
// - G.704 style alignment words per frame
// - internal mode uses local oscillator timing
// - loop mode uses recovered line timing
// - only one link end supplies timing
// - multiplexer links should use loop timing
// - six static selection inputs, per-channel mode
// - channel 1 electrical, channel 2 fiber
`timescale 1ns/1ps
`include "tol_defs.vh"
module tol_link_timing #(
    parameter FRAME_BITS = `TOL_FRAME_BITS
)(
    input wire clk_sys,
    input wire arst_n,
    input wire [5:0] sel_sw,
    input wire rx_clk_ch1,
    input wire rx_clk_ch2,
    input wire [7:0] pay_ch1,
    input wire [7:0] pay_ch2,
    output wire pay_take_ch1,
    output wire pay_take_ch2,
    output reg tx_elec_ff,
    output reg tx_fiber_ff,
    output reg [1:0] mode_ff,
    output reg [5:0] sel_ff
);
    reg [2:0] sw_s1_ff;
    reg [5:0] sw_m_ff;
    reg [5:0] sw_s2_ff;
    reg cap_done_ff;
    wire [1:0] tick;
    wire [1:0] rx_clk;
    wire [1:0] take_v;
    wire [7:0] pay [0:1];
    wire [1:0] serial;
    // per-channel views of the pins so one generate loop serves both
    assign pay[0] = pay_ch1;
    assign pay[1] = pay_ch2;
    assign rx_clk[0] = rx_clk_ch1;
    assign rx_clk[1] = rx_clk_ch2;
    // switch pins pass two flip-flops before anything reads them
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sw_m_ff <= 6'h0;
            sw_s2_ff <= 6'h0;
        end
        else
        begin
            sw_m_ff <= sel_sw;
            sw_s2_ff <= sw_m_ff;
        end
    end
    // release delay: lets the synchronised switches settle first
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            sw_s1_ff <= 3'h0;
        else
            sw_s1_ff <= {sw_s1_ff[1:0], 1'b1};
    end
    // latch switches once, later changes wait for a reset
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cap_done_ff <= 1'b0;
            sel_ff <= 6'h0;
            mode_ff <= 2'h0;
        end
        else if (!cap_done_ff && sw_s1_ff[2])
        begin
            cap_done_ff <= 1'b1;
            // six inputs, one mode bit per channel
            sel_ff <= sw_s2_ff;
            // timing source set only by the switches
            mode_ff <= {sw_s2_ff[`TOL_SW_CH2_MODE], sw_s2_ff[`TOL_SW_CH1_MODE]};
        end
    end
    // per-channel framer; channel 0 electrical, channel 1 fiber
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1)
        begin : g_ch
            reg [7:0] bit_ff;
            reg frm_odd_ff;
            reg [7:0] shf_ff;
            reg tx_ff;
            wire step;
            wire last_bit;
            wire octet_end;
            tol_bit_clock #(
                .HALF(`TOL_BIT_DIV_HALF)
            ) u_clk (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .mode_int(mode_ff[c]),
                .rx_clk_in(rx_clk[c]),
                .bit_tick_ff(tick[c])
            );
            // framing waits until the switches are latched
            assign step = tick[c] & cap_done_ff;
            assign last_bit = (bit_ff == FRAME_BITS[7:0] - 8'h1);
            assign octet_end = (bit_ff[2:0] == 3'h7);
            // one payload octet per frame in timeslot 1
            assign take_v[c] = step & (bit_ff == 8'h7);
            // 256 bits per frame, wraps each frame
            always @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                    bit_ff <= 8'h0;
                else if (step)
                    bit_ff <= bit_ff + 8'h1;
            end
            // frame parity picks which alignment word comes next
            always @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                    frm_odd_ff <= 1'b0;
                else if (step && last_bit)
                    frm_odd_ff <= ~frm_odd_ff;
            end
            // octet shifter, msb first, reloaded at each octet end
            always @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                    shf_ff <= 8'h0;
                else if (step)
                begin
                    if (octet_end)
                    begin
                        if (last_bit)
                            shf_ff <= frm_odd_ff ? `TOL_FAS_PATTERN : `TOL_NFAS_PATTERN;
                        else if (take_v[c])
                            shf_ff <= pay[c];
                        else
                            shf_ff <= `TOL_IDLE_OCTET;
                    end
                    else
                        shf_ff <= {shf_ff[6:0], 1'b1};
                end
            end
            // line bit, idles high until framing starts
            always @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                    tx_ff <= 1'b1;
                else if (step)
                    tx_ff <= shf_ff[7];
            end
            assign serial[c] = tx_ff;
        end
    endgenerate
    // payload handshake pulses, one per frame and channel
    assign pay_take_ch1 = take_v[0];
    assign pay_take_ch2 = take_v[1];
    // channel 1 to electrical, channel 2 to fiber
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_elec_ff <= 1'b1;
            tx_fiber_ff <= 1'b1;
        end
        else
        begin
            tx_elec_ff <= serial[0];
            tx_fiber_ff <= serial[1];
        end
    end
endmodule

// >>> inc/tol_defs.vh
// constants for the teleprotection optical link timing block
`ifndef TOL_DEFS_VH
`define TOL_DEFS_VH
`define TOL_CLK_HZ 20000000
`define TOL_LINE_BPS 2048000
`define TOL_FRAME_BITS 256
`define TOL_FRAME_HZ 8000
`define TOL_PAYLOAD_BPS 64000
`define TOL_RATE_MULT 1
`define TOL_SW_COUNT 6
`define TOL_SW_CH1_MODE 0
`define TOL_SW_CH2_MODE 1
`define TOL_MODE_LOOP 1'b0
`define TOL_MODE_INT 1'b1
`define TOL_BIT_DIV_HALF 5
`define TOL_SLOT_FIRST 8
`define TOL_SLOT_LAST 15
`define TOL_FAS_PATTERN 8'h1b
`define TOL_NFAS_PATTERN 8'h40
`define TOL_IDLE_OCTET 8'hff
`endif

// >>> verilog/tol_bit_clock.v
// per-channel bit timing: local divider or recovered line edges
`timescale 1ns/1ps
`include "tol_defs.vh"
module tol_bit_clock #(
    parameter HALF = `TOL_BIT_DIV_HALF
)(
    input wire clk_sys,
    input wire arst_n,
    input wire mode_int,
    input wire rx_clk_in,
    output reg bit_tick_ff
);
    reg [2:0] sync_ff;
    reg [3:0] div_ff;
    reg phase_ff;
    // two-stage synchroniser, then edge history
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_ff <= 3'h0;
            div_ff <= 4'h0;
            phase_ff <= 1'b0;
            bit_tick_ff <= 1'b0;
        end
        else
        begin
            sync_ff <= {sync_ff[1:0], rx_clk_in};
            if (div_ff == HALF[3:0] - 4'h1)
            begin
                div_ff <= 4'h0;
                phase_ff <= ~phase_ff;
            end
            else
                div_ff <= div_ff + 4'h1;
            if (mode_int == `TOL_MODE_INT)
                bit_tick_ff <= (div_ff == HALF[3:0] - 4'h1) & phase_ff;
            else
                bit_tick_ff <= sync_ff[1] & ~sync_ff[2];
        end
    end
endmodule

// >>> bench/tol_link_monitor.sv
// assertion checker for the link timing block
`timescale 1ns/1ps
module tol_link_monitor(
    input wire clk_sys, arst_n, rx_clk_ch1, rx_clk_ch2, pay_take_ch1, pay_take_ch2,
    input wire tx_elec_ff, tx_fiber_ff,
    input wire [1:0] mode_ff,
    input wire [5:0] sel_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    take_one_a: assert property (pay_take_ch1 |=> !pay_take_ch1) else $error("take1");
    take_two_a: assert property (pay_take_ch2 |=> !pay_take_ch2) else $error("take2");
    sel_hold_a: assert property (sel_ff != 6'h00 |=> $stable(sel_ff)) else $error("sel");
    mode_sel_a: assert property ($stable(sel_ff) && $stable(mode_ff) |-> mode_ff == sel_ff[1:0])
        else $error("mode");
    int_bit1_a: assert property (mode_ff[0] && $changed(tx_elec_ff) |=> $stable(tx_elec_ff)[*8])
        else $error("bit1");
    int_bit2_a: assert property (mode_ff[1] && $changed(tx_fiber_ff) |=> $stable(tx_fiber_ff)[*8])
        else $error("bit2");
    loop_bit1_a: assert property ((!mode_ff[0] && $stable(rx_clk_ch1))[*8] |=> $stable(tx_elec_ff))
        else $error("loop1");
    loop_bit2_a: assert property ((!mode_ff[1] && $stable(rx_clk_ch2))[*8] |=> $stable(tx_fiber_ff))
        else $error("loop2");
endmodule
bind tol_link_timing tol_link_monitor u_mon(.clk_sys(clk_sys), .arst_n(arst_n),
    .rx_clk_ch1(rx_clk_ch1), .rx_clk_ch2(rx_clk_ch2), .pay_take_ch1(pay_take_ch1),
    .pay_take_ch2(pay_take_ch2), .tx_elec_ff(tx_elec_ff), .tx_fiber_ff(tx_fiber_ff),
    .mode_ff(mode_ff), .sel_ff(sel_ff));

// >>> bench/tol_far_end.sv
// far-end line clock source, stands still while idle
`timescale 1ns/1ps
module tol_far_end #(
    parameter HALF_NS = 244
)(
    input wire run,
    output reg rx_clk_ch1 = 1'b0,
    output reg rx_clk_ch2 = 1'b0
);
    // far end supplies a 2048 kbps bit clock
    always #HALF_NS
        if (run)
        begin
            rx_clk_ch1 = ~rx_clk_ch1;
            rx_clk_ch2 = ~rx_clk_ch2;
        end
endmodule

// >>> bench/tol_link_timing_test.sv
// self-checking bench for the link timing block
`timescale 1ns/1ps
module tol_link_timing_test;
    reg clk_sys = 0, arst_n = 0, run = 0;
    reg [5:0] sel_sw = 6'h00;
    wire r1, r2, t1, t2, te, tf;
    wire [1:0] md;
    wire [5:0] sf;
    integer n_errors = 0, n_tests = 0, n_cyc = 0, c;
    always #25 clk_sys = ~clk_sys;
    tol_link_timing u_dut(.clk_sys(clk_sys), .arst_n(arst_n), .sel_sw(sel_sw), .rx_clk_ch1(r1),
        .rx_clk_ch2(r2), .pay_ch1(8'ha5), .pay_ch2(8'h3c), .pay_take_ch1(t1), .pay_take_ch2(t2),
        .tx_elec_ff(te), .tx_fiber_ff(tf), .mode_ff(md), .sel_ff(sf));
    tol_far_end u_far(.run(run), .rx_clk_ch1(r1), .rx_clk_ch2(r2));
    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task chk(input string nm, input integer lo, input integer hi, input [31:0] got);
    begin
        n_tests = n_tests + 1;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            n_errors = n_errors + 1;
            $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, got);
        end
    end
    endtask
    // cycles until the next take, capped at 3000
    task wt(input integer ch);
    begin
        c = 1;
        @(negedge clk_sys);
        while ((ch == 1 ? t1 : t2) !== 1'b1 && c < 3000)
        begin
            @(negedge clk_sys);
            c = c + 1;
        end
    end
    endtask
    task frm(input integer ch, input integer lo, input integer hi);
    begin
        wt(ch);
        wt(ch);
        chk("frame", lo, hi, c);
    end
    endtask
    // payload octet on the line, internal timing, msb first
    task oct(input integer ch, input [7:0] e);
        integer i;
        reg [7:0] v;
    begin
        v = 8'h00;
        wt(ch);
        repeat (6) @(negedge clk_sys);
        for (i = 0; i < 8; i = i + 1)
        begin
            repeat (10) @(negedge clk_sys);
            v = {v[6:0], (ch == 1 ? te : tf)};
        end
        chk("octet", e, e, v);
    end
    endtask
    task rst(input [5:0] s);
    begin
        @(posedge clk_sys) #5 arst_n = 0;
        sel_sw = s;
        repeat (20) @(posedge clk_sys);
        chk("idle", 3, 3, {te, tf});
        #5 arst_n = 1;
        repeat (6) @(posedge clk_sys);
        chk("sel", s, s, sf);
        chk("mode", s[1:0], s[1:0], md);
    end
    endtask
    // main sequence: internal timing, late switch change, loop timing
    initial
    begin
        rst(6'h2b);
        frm(1, 2560, 2560);
        frm(2, 2560, 2560);
        oct(1, 8'ha5);
        oct(2, 8'h3c);
        @(posedge clk_sys) #5 sel_sw = 6'h10;
        repeat (5) @(posedge clk_sys);
        chk("hold", 6'h2b, 6'h2b, sf);
        rst(6'h01);
        @(posedge clk_sys) #5 run = 1;
        frm(2, 2497, 2500);
        frm(1, 2560, 2560);
        @(posedge clk_sys) #5 run = 0;
        wt(2);
        chk("stop", 3000, 3000, c);
        wrap_up;
    end
    // hang guard
    always @(posedge clk_sys)
    begin
        n_cyc = n_cyc + 1;
        if (n_cyc == 40000)
        begin
            n_errors = n_errors + 1;
            wrap_up;
        end
    end
endmodule
